// ==== design/dfc_top.sv ====
`timescale 1ns/100ps
module dfc_top
#(
  parameter int TENTH_S_CYCLES = dfc_pkg::TENTH_S_CYC,
  parameter int SOFT_STEP_CYCLES = dfc_pkg::SOFT_STEP_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dfc_pkg::dfc_cfg_t cfg_in,
  input wire logic [4:0] terminal_in,
  input wire logic forward_run_input_in,
  input wire logic reverse_run_input_in,
  input wire logic [15:0] output_freq_setpoint_in,
  input wire logic setpoint_write_in,
  input wire logic [15:0] pid_out_in,
  input wire logic pid_enable_in,
  output dfc_pkg::dfc_out_t status_out,
  output logic [15:0] inch_freq_stored_out
);
  import dfc_pkg::*;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [4:0] t_meta;
    logic [4:0] t_sync;
    logic [1:0] run_meta;
    logic [1:0] run_sync;
    dfc_mode_t mode;
    logic [15:0] freq;
    logic [15:0] inch_freq;
    logic inch_blocked;
    logic [31:0] timer;
    logic [9:0] volt;
    logic [31:0] vtimer;
    logic apause_done;
    logic dpause_done;
    dfc_out_t outs;
  } dfc_state_t;

  dfc_state_t st_r;
  dfc_state_t st_nxt;
  logic rst_n;

  assign rst_n = st_r.rst_sync[1];

  // True when any terminal selects the given function and is on
  function automatic logic term_on(input logic [39:0] sel,
    input logic [4:0] t, input logic [7:0] fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++)
    begin
      if (sel[i*8 +: 8] == fn && t[i])
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : term_on

  function automatic logic term_assigned(input logic [39:0] sel,
    input logic [7:0] fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++)
    begin
      if (sel[i*8 +: 8] == fn)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : term_assigned

  // Clamp with zero limits inactive
  function automatic logic [15:0] clamp_f(input logic [15:0] f,
    input logic [15:0] hi, input logic [15:0] lo);
    logic [15:0] r;
    r = f;
    if (hi != 16'h0000 && r > hi)
    begin
      r = hi;
    end
    if (lo != 16'h0000 && r < lo)
    begin
      r = lo;
    end
    return r;
  endfunction : clamp_f

  // Move a steady target out of any enabled skip band
  function automatic logic [15:0] skip_f(input logic [15:0] f,
    input logic [47:0] c, input logic [47:0] w);
    logic [15:0] r;
    logic [16:0] top;
    logic [15:0] hw;
    r = f;
    top = 17'h0_0000;
    hw = 16'h0000;
    for (int i = 0; i < NUM_BANDS; i++)
    begin
      hw = (w[i*16 +: 16] > HALF_WIDTH_MAX) ? HALF_WIDTH_MAX : w[i*16 +: 16];
      top = {1'b0, c[i*16 +: 16]} + {1'b0, hw};
      if (c[i*16 +: 16] != 16'h0000 && r < top[15:0] &&
          {1'b0, r} + {1'b0, hw} > {1'b0, c[i*16 +: 16]})
      begin
        r = (r < c[i*16 +: 16]) ? c[i*16 +: 16] - hw : top[15:0];
      end
    end
    return r;
  endfunction : skip_f

  logic run_cmd;
  logic permit_ok;
  logic inch_on;
  logic freeze_on;
  logic [15:0] floor_eff;
  logic [15:0] start_f;
  logic [15:0] target;
  logic [15:0] step;
  logic [15:0] cmd_src;
  logic [15:0] inch_lim;
  logic [15:0] inch_eff;
  logic [31:0] soft_len;

  always_comb
  begin
    start_f = (cfg_in.initial_output_freq < START_FREQ_MIN) ? START_FREQ_MIN :
      (cfg_in.initial_output_freq > START_FREQ_MAX) ? START_FREQ_MAX :
      cfg_in.initial_output_freq;
    floor_eff = cfg_in.freq_floor;
    if (floor_eff != 16'h0000 && floor_eff < start_f)
    begin
      floor_eff = start_f;
    end
    if (cfg_in.freq_ceiling != 16'h0000 && floor_eff > cfg_in.freq_ceiling)
    begin
      floor_eff = cfg_in.freq_ceiling;
    end
    permit_ok = !term_assigned(cfg_in.input_terminal_function_sel,
      FN_PERMIT) || term_on(cfg_in.input_terminal_function_sel,
      st_r.t_sync, FN_PERMIT);
    run_cmd = (st_r.run_sync != 2'b00) && permit_ok;
    inch_on = term_on(cfg_in.input_terminal_function_sel, st_r.t_sync,
      FN_INCH);
    freeze_on = term_on(cfg_in.input_terminal_function_sel, st_r.t_sync,
      FN_FREEZE);
    cmd_src = pid_enable_in ? pid_out_in : output_freq_setpoint_in;
    target = run_cmd ? skip_f(clamp_f(cmd_src, cfg_in.freq_ceiling,
      floor_eff), cfg_in.skip_band_center, cfg_in.skip_band_half_width)
      : 16'h0000;
    if (target > cfg_in.max_output_freq)
    begin
      target = cfg_in.max_output_freq;
    end
    step = (cfg_in.ramp_step == 16'h0000) ? 16'h0001 : cfg_in.ramp_step;
    inch_lim = output_freq_setpoint_in;
    if (inch_lim < start_f)
    begin
      inch_lim = start_f;
    end
    if (inch_lim > INCH_FREQ_MAX)
    begin
      inch_lim = INCH_FREQ_MAX;
    end
    // Configured inch frequency until a setpoint write in inch mode replaces it
    inch_eff = (st_r.inch_freq != 16'h0000) ? st_r.inch_freq :
      cfg_in.inch_freq_setting;
    if (inch_eff < start_f)
    begin
      inch_eff = start_f;
    end
    if (inch_eff > INCH_FREQ_MAX)
    begin
      inch_eff = INCH_FREQ_MAX;
    end
    soft_len = 32'(SOFT_STEP_CYCLES);
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.t_meta = terminal_in;
    st_nxt.t_sync = st_r.t_meta;
    st_nxt.run_meta = {reverse_run_input_in, forward_run_input_in};
    st_nxt.run_sync = st_r.run_meta;
    st_nxt.outs.run_rejected = (st_r.run_sync != 2'b00) && !permit_ok;
    st_nxt.outs.coast = 1'b0;
    st_nxt.outs.dc_brake = 1'b0;
    if (setpoint_write_in && st_r.mode == DFC_INCH)
    begin
      st_nxt.inch_freq = inch_lim;
    end
    if (st_r.run_sync == 2'b00)
    begin
      st_nxt.inch_blocked = 1'b0;
    end
    else if (!inch_on && cfg_in.inch_stop_sel < INCH_STOP_GRP &&
      st_r.mode != DFC_INCH)
    begin
      st_nxt.inch_blocked = 1'b1;
    end
    if (st_r.timer != 32'h0000_0000)
    begin
      st_nxt.timer = st_r.timer - 32'h0000_0001;
    end
    unique case (st_r.mode)
      DFC_IDLE, DFC_RAMP:
      begin
        if (inch_on && run_cmd && (cfg_in.inch_stop_sel >= INCH_STOP_GRP ||
          (!st_r.inch_blocked && st_r.freq == 16'h0000)))
        begin
          st_nxt.mode = DFC_INCH;
          st_nxt.freq = inch_eff;
        end
        else if (freeze_on)
        begin
          st_nxt.freq = st_r.freq;
        end
        else if (run_cmd && st_r.freq == 16'h0000)
        begin
          st_nxt.mode = DFC_RAMP;
          st_nxt.freq = start_f;
          st_nxt.volt = (cfg_in.soft_voltage_ramp_sel == 8'h00) ?
            VOLT_FULL : 10'h000;
          st_nxt.vtimer = 32'h0000_0000;
          st_nxt.apause_done = 1'b0;
          st_nxt.dpause_done = 1'b0;
        end
        else if (st_r.freq < target)
        begin
          // Continuous sweep through skip bands
          st_nxt.freq = (target - st_r.freq > step) ? st_r.freq + step
            : target;
          if (!st_r.apause_done && cfg_in.accel_pause_freq != 16'h0000 &&
            cfg_in.accel_pause_freq <= PAUSE_FREQ_MAX &&
            st_r.freq < cfg_in.accel_pause_freq &&
            st_nxt.freq >= cfg_in.accel_pause_freq)
          begin
            st_nxt.freq = cfg_in.accel_pause_freq;
            st_nxt.mode = DFC_APAUSE;
            st_nxt.apause_done = 1'b1;
            st_nxt.timer = 32'(((cfg_in.accel_pause_time > PAUSE_TIME_MAX) ?
              PAUSE_TIME_MAX : cfg_in.accel_pause_time) * TENTH_S_CYCLES);
          end
        end
        else if (st_r.freq > target)
        begin
          st_nxt.freq = (st_r.freq - target > step) ? st_r.freq - step
            : target;
          if (target == 16'h0000 && st_nxt.freq < start_f)
          begin
            st_nxt.freq = 16'h0000;
          end
          if (!st_r.dpause_done && cfg_in.decel_pause_freq != 16'h0000 &&
            st_r.freq > cfg_in.decel_pause_freq &&
            st_nxt.freq <= cfg_in.decel_pause_freq)
          begin
            st_nxt.freq = cfg_in.decel_pause_freq;
            st_nxt.mode = DFC_DPAUSE;
            st_nxt.dpause_done = 1'b1;
            st_nxt.timer = 32'(((cfg_in.decel_pause_time > PAUSE_TIME_MAX) ?
              PAUSE_TIME_MAX : cfg_in.decel_pause_time) * TENTH_S_CYCLES);
          end
        end
        else if (st_r.freq == 16'h0000)
        begin
          st_nxt.mode = DFC_IDLE;
        end
        if (st_r.freq == target)
        begin
          st_nxt.apause_done = 1'b0;
          st_nxt.dpause_done = 1'b0;
        end
      end
      DFC_APAUSE, DFC_DPAUSE:
      begin
        if (st_r.timer <= 32'h0000_0001)
        begin
          st_nxt.mode = DFC_RAMP;
        end
      end
      DFC_INCH:
      begin
        st_nxt.freq = setpoint_write_in ? inch_lim : inch_eff;
        if (!inch_on || !run_cmd)
        begin
          st_nxt.mode = DFC_IDLE;
          st_nxt.freq = 16'h0000;
          if (run_cmd || cfg_in.inch_stop_sel == 3'h0 ||
            cfg_in.inch_stop_sel == INCH_STOP_GRP)
          begin
            st_nxt.outs.coast = 1'b1;
          end
          else if (cfg_in.inch_stop_sel == 3'h2 ||
            cfg_in.inch_stop_sel == 3'h5)
          begin
            st_nxt.outs.dc_brake = 1'b1;
          end
          else
          begin
            st_nxt.mode = DFC_RAMP;
            st_nxt.freq = st_r.freq;
          end
        end
      end
      default:
      begin
        st_nxt.mode = DFC_IDLE;
      end
    endcase
    // Voltage soft start
    if (cfg_in.soft_voltage_ramp_sel == 8'h00)
    begin
      st_nxt.volt = VOLT_FULL;
    end
    else if (st_nxt.volt < VOLT_FULL)
    begin
      if (st_nxt.vtimer + 32'h0000_0001 >=
        soft_len * 32'(cfg_in.soft_voltage_ramp_sel))
      begin
        st_nxt.vtimer = 32'h0000_0000;
        st_nxt.volt = st_nxt.volt + 10'h001;
      end
      else
      begin
        st_nxt.vtimer = st_nxt.vtimer + 32'h0000_0001;
      end
    end
    if (st_nxt.freq == 16'h0000)
    begin
      st_nxt.volt = 10'h000;
    end
    st_nxt.outs.out_freq = st_nxt.freq;
    st_nxt.outs.volt_permille = st_nxt.volt;
    st_nxt.outs.running = st_nxt.freq != 16'h0000;
    st_nxt.outs.inch_active = st_nxt.mode == DFC_INCH;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
    end
    else if (!rst_n)
    begin
      st_r <= '0;
      st_r.rst_sync <= {st_r.rst_sync[0], 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign inch_freq_stored_out = st_r.inch_freq;
  assign status_out = st_r.outs;
endmodule : dfc_top

// ==== design/dfc_pkg.sv ====
package dfc_pkg;
  // Frequencies in 0.01 Hz units, times in 0.1 s units
  localparam int FREQ_W = 16;
  localparam logic [7:0] FN_INCH = 8'h06;
  localparam logic [7:0] FN_FREEZE = 8'h53;
  localparam logic [7:0] FN_PERMIT = 8'h54;
  localparam int NUM_TERMS = 5;
  localparam int NUM_BANDS = 3;
  localparam logic [15:0] START_FREQ_MIN = 16'h0001;
  localparam logic [15:0] START_FREQ_MAX = 16'h03E7;
  localparam logic [15:0] INCH_FREQ_MAX = 16'h03E7;
  localparam logic [15:0] HALF_WIDTH_MAX = 16'h03E8;
  localparam logic [15:0] PAUSE_FREQ_MAX = 16'h9C40;
  localparam logic [15:0] PAUSE_TIME_MAX = 16'h0258;
  localparam logic [7:0] SOFT_SEL_MAX = 8'hFA;
  localparam int CLK_HZ = 100000000;
  localparam int SOFT_STEP_US = 4;
  localparam int SOFT_STEP_CYC = SOFT_STEP_US * (CLK_HZ / 1000000);
  localparam int TENTH_S_MS = 100;
  localparam int TENTH_S_CYC = TENTH_S_MS * (CLK_HZ / 1000);
  localparam logic [2:0] INCH_STOP_GRP = 3'h3;
  localparam logic [9:0] VOLT_FULL = 10'h3E8;

  typedef enum logic [1:0] {DFC_STOP_COAST, DFC_STOP_DECEL, DFC_STOP_DCB}
    dfc_stop_t;
  typedef enum logic [2:0] {DFC_IDLE, DFC_RAMP, DFC_APAUSE, DFC_DPAUSE,
    DFC_INCH} dfc_mode_t;

  typedef struct packed {
    logic [15:0] initial_output_freq;
    logic [7:0] soft_voltage_ramp_sel;
    logic [15:0] inch_freq_setting;
    logic [2:0] inch_stop_sel;
    logic [15:0] freq_ceiling;
    logic [15:0] freq_floor;
    logic [15:0] max_output_freq;
    logic [47:0] skip_band_center;
    logic [47:0] skip_band_half_width;
    logic [15:0] accel_pause_freq;
    logic [15:0] accel_pause_time;
    logic [15:0] decel_pause_freq;
    logic [15:0] decel_pause_time;
    logic [39:0] input_terminal_function_sel;
    logic [15:0] ramp_step;
  } dfc_cfg_t;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [9:0] volt_permille;
    logic running;
    logic inch_active;
    logic coast;
    logic dc_brake;
    logic run_rejected;
  } dfc_out_t;
endpackage : dfc_pkg

// ==== dv/dfc_partner.sv ====
`timescale 1ns/100ps
module dfc_partner
(
  input wire logic clk_in,
  input wire logic inch_req_in,
  input wire logic run_req_in,
  output logic inch_out,
  output logic run_out
);
  initial
  begin
    inch_out = 1'b0;
    run_out = 1'b0;
  end
  // Run waits one cycle behind a requested inch
  always @(negedge clk_in)
  begin
    inch_out <= inch_req_in;
    run_out <= run_req_in && (inch_out || !inch_req_in || run_out);
  end
endmodule : dfc_partner

// ==== dv/dfc_chk.sv ====
`timescale 1ns/100ps
module dfc_chk
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dfc_pkg::dfc_cfg_t cfg_in,
  input wire logic [4:0] terminal_in,
  input wire dfc_pkg::dfc_out_t status_out
);
  import dfc_pkg::*;
  dfc_out_t s;
  logic fz;
  logic [3:0] hold_r;
  assign s = status_out;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  function automatic logic in_band(input logic [15:0] f);
    logic hit;
    logic [16:0] c;
    logic [16:0] w;
    hit = 1'b0;
    for (int b = 0; b < NUM_BANDS; b++)
    begin
      c = {1'b0, cfg_in.skip_band_center[16*b +: 16]};
      w = {1'b0, cfg_in.skip_band_half_width[16*b +: 16]};
      if (c != 17'h0_0000 && {1'b0, f} + w > c && {1'b0, f} < c + w)
        hit = 1'b1;
    end
    return hit;
  endfunction : in_band
  always_comb
  begin
    fz = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++)
      if (cfg_in.input_terminal_function_sel[8*i +: 8] == FN_FREEZE)
        fz = fz | terminal_in[i];
  end
  // Cycles the freeze pin has been high
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      hold_r <= 4'h0;
    else if (!fz)
      hold_r <= 4'h0;
    else if (hold_r != 4'hF)
      hold_r <= hold_r + 4'h1;
  a_volt_bounded: assert property (
    s.volt_permille <= VOLT_FULL)
    else $error("voltage above full");
  a_volt_rising: assert property (
    s.running && $past(s.running) |->
    s.volt_permille >= $past(s.volt_permille))
    else $error("voltage fell while running");
  a_coast_pulse: assert property (
    s.coast |=> !s.coast)
    else $error("coast pulse too long");
  a_brake_pulse: assert property (
    s.dc_brake |=> !s.dc_brake)
    else $error("brake pulse too long");
  a_start_freq: assert property (
    $rose(s.running) && !s.inch_active |->
    ##[0:1] s.out_freq == cfg_in.initial_output_freq)
    else $error("start not at start frequency");
  a_ceiling_clamp: assert property (
    s.running && !s.inch_active && cfg_in.freq_ceiling != 16'h0000 |->
    s.out_freq <= cfg_in.freq_ceiling)
    else $error("output above ceiling");
  a_permit_gate: assert property (
    s.run_rejected |-> !$rose(s.running))
    else $error("run started without permit");
  a_skip_steady: assert property (
    (s.running && !s.inch_active && $stable(s.out_freq)) [*8] |->
    !in_band(s.out_freq))
    else $error("steady output inside skip band");
  a_ramp_rate: assert property (
    s.running && $past(s.running) && !s.inch_active &&
    !$past(s.inch_active) |->
    s.out_freq <= $past(s.out_freq) + cfg_in.ramp_step &&
    $past(s.out_freq) <= s.out_freq + cfg_in.ramp_step)
    else $error("ramp step too large");
  a_freeze_hold: assert property (
    hold_r >= 4'h7 && s.running && !s.inch_active |-> $stable(s.out_freq))
    else $error("frequency moved while frozen");
endmodule : dfc_chk
bind dfc_top dfc_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .cfg_in(cfg_in), .terminal_in(terminal_in), .status_out(status_out));

// ==== dv/dfc_top_tb_top.sv ====
`timescale 1ns/100ps
module dfc_top_tb_top;
  import dfc_pkg::*;
  typedef struct packed {
    logic [15:0] sp;
    logic pe;
    logic [15:0] pid;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] ex;
  } dfc_row_t;
  localparam dfc_row_t ROWS [8] = '{
    '{16'h1388, 1'b0, 16'h0000, 16'h1770, 16'h01F4, 16'h1388},
    '{16'h2000, 1'b0, 16'h0000, 16'h1770, 16'h01F4, 16'h1770},
    '{16'h0064, 1'b0, 16'h0000, 16'h1770, 16'h01F4, 16'h01F4},
    '{16'h2000, 1'b0, 16'h0000, 16'h0000, 16'h01F4, 16'h2000},
    '{16'h0064, 1'b0, 16'h0000, 16'h1770, 16'h0000, 16'h0064},
    '{16'h0FB4, 1'b0, 16'h0000, 16'h1770, 16'h01F4, 16'h1068},
    '{16'h0B86, 1'b0, 16'h0000, 16'h1770, 16'h01F4, 16'h0B54},
    '{16'h0100, 1'b1, 16'h2500, 16'h1770, 16'h01F4, 16'h1770}
  };
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic inch_req = 1'b0;
  logic run_req = 1'b0;
  logic fz = 1'b0;
  logic ok = 1'b1;
  logic wr = 1'b0;
  logic pe = 1'b0;
  logic rev = 1'b0;
  logic saw_c = 1'b0;
  logic saw_b = 1'b0;
  logic inch_pin;
  logic run_pin;
  logic [15:0] sp = 16'h0000;
  logic [15:0] pid = 16'h0000;
  logic [15:0] f;
  logic [15:0] stored;
  dfc_cfg_t cfg;
  dfc_out_t st;
  int fails = 0;
  int check_count = 0;
  int n;
  always #5 clk_in = ~clk_in;
  dfc_partner u_part (.clk_in(clk_in), .inch_req_in(inch_req),
    .run_req_in(run_req), .inch_out(inch_pin), .run_out(run_pin));
  dfc_top #(.TENTH_S_CYCLES(10), .SOFT_STEP_CYCLES(2)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
    .terminal_in({2'b00, ok, fz, inch_pin}),
    .forward_run_input_in(run_pin), .reverse_run_input_in(rev),
    .output_freq_setpoint_in(sp), .setpoint_write_in(wr),
    .pid_out_in(pid), .pid_enable_in(pe), .status_out(st),
    .inch_freq_stored_out(stored));
  always @(posedge clk_in)
  begin
    if (st.coast === 1'b1)
      saw_c <= 1'b1;
    if (st.dc_brake === 1'b1)
      saw_b <= 1'b1;
  end
  task automatic check(input string nm, input logic [31:0] v,
    input logic [31:0] e);
    check_count++;
    if (v !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", nm, e, v);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc
  task automatic settle(input logic [15:0] v);
    for (int i = 0; i < 3000 && st.out_freq !== v; i++)
      cyc(1);
  endtask : settle
  task automatic dwell(input logic [15:0] v);
    settle(v);
    n = 0;
    while (st.out_freq === v && n < 99)
    begin
      cyc(1);
      n++;
    end
  endtask : dwell
  task automatic stop;
    run_req <= 1'b0;
    inch_req <= 1'b0;
    settle(16'h0000);
    cyc(10);
  endtask : stop
  task automatic conclude;
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial
  begin
    cfg = '0;
    cfg.initial_output_freq = 16'h0030;
    cfg.soft_voltage_ramp_sel = 8'h02;
    cfg.inch_stop_sel = 3'h3;
    cfg.freq_ceiling = 16'h1770;
    cfg.freq_floor = 16'h01F4;
    cfg.max_output_freq = 16'h2710;
    cfg.skip_band_center = {16'h0BB8, 16'h0000, 16'h0FA0};
    cfg.skip_band_half_width = {16'h0064, 16'h03E8, 16'h00C8};
    cfg.accel_pause_freq = 16'h07D0;
    cfg.accel_pause_time = 16'h0002;
    cfg.decel_pause_freq = 16'h0388;
    cfg.decel_pause_time = 16'h0002;
    cfg.input_terminal_function_sel = {16'h0000, FN_PERMIT, FN_FREEZE,
      FN_INCH};
    cfg.ramp_step = 16'h0010;
    cyc(4);
    check("rst", 32'(st), 32'h0000_0000);
    rst_n_in <= 1'b1;
    cyc(6);
    foreach (ROWS[i])
    begin
      cfg.freq_ceiling <= ROWS[i].hi;
      cfg.freq_floor <= ROWS[i].lo;
      sp <= ROWS[i].sp;
      pid <= ROWS[i].pid;
      pe <= ROWS[i].pe;
      run_req <= 1'b1;
      cyc(2);
      settle(ROWS[i].ex);
      cyc(20);
      check("row", 32'(st.out_freq), 32'(ROWS[i].ex));
      stop();
    end
    sp <= 16'h1388;
    pe <= 1'b0;
    cfg.freq_ceiling <= 16'h1770;
    cfg.freq_floor <= 16'h01F4;
    run_req <= 1'b1;
    dwell(16'h07D0);
    check("a_hold", 32'(n >= 19 && n <= 21), 32'h0000_0001);
    settle(16'h1388);
    run_req <= 1'b0;
    dwell(16'h0388);
    check("d_hold", 32'(n >= 19 && n <= 21), 32'h0000_0001);
    stop();
    run_req <= 1'b1;
    settle(16'h0A30);
    fz <= 1'b1;
    cyc(8);
    f = st.out_freq;
    cyc(40);
    check("frz", 32'(st.out_freq), 32'(f));
    fz <= 1'b0;
    settle(16'h1388);
    check("resume", 32'(st.out_freq), 32'h0000_1388);
    stop();
    ok <= 1'b0;
    run_req <= 1'b1;
    cyc(10);
    check("rej", 32'(st.run_rejected), 32'h0000_0001);
    check("idle", 32'(st.running), 32'h0000_0000);
    ok <= 1'b1;
    cyc(10);
    check("run", 32'(st.running), 32'h0000_0001);
    stop();
    rev <= 1'b1;
    cyc(10);
    check("rev", 32'(st.running), 32'h0000_0001);
    rev <= 1'b0;
    stop();
    for (int s = 0; s < 3; s++)
    begin
      cfg.soft_voltage_ramp_sel <= 8'(s);
      run_req <= 1'b1;
      n = 0;
      while (st.volt_permille !== VOLT_FULL && n < 9000)
      begin
        cyc(1);
        n++;
      end
      check("soft", 32'(n / 100), 32'(s * 20));
      stop();
    end
    inch_req <= 1'b1;
    run_req <= 1'b1;
    cyc(10);
    check("inch", 32'(st.inch_active), 32'h0000_0001);
    check("inch_f", 32'(st.out_freq), 32'h0000_0030);
    sp <= 16'h01F4;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(6);
    check("inch_w", 32'(st.out_freq), 32'h0000_01F4);
    check("stored", 32'(stored), 32'h0000_01F4);
    saw_c <= 1'b0;
    inch_req <= 1'b0;
    cyc(10);
    check("coast", 32'(saw_c), 32'h0000_0001);
    stop();
    for (int c = 0; c < 6; c++)
    begin
      cfg.inch_stop_sel <= 3'(c);
      run_req <= 1'b1;
      cyc(10);
      inch_req <= 1'b1;
      cyc(10);
      check("late", 32'(st.inch_active), 32'(c > 2));
      stop();
      saw_c <= 1'b0;
      saw_b <= 1'b0;
      inch_req <= 1'b1;
      run_req <= 1'b1;
      cyc(10);
      run_req <= 1'b0;
      cyc(20);
      check("stop_c", 32'(saw_c), 32'(c % 3 == 0));
      check("stop_b", 32'(saw_b), 32'(c % 3 == 2));
      stop();
    end
    cfg.input_terminal_function_sel[7:0] <= 8'h00;
    inch_req <= 1'b1;
    run_req <= 1'b1;
    cyc(10);
    check("no_fn", 32'(st.inch_active), 32'h0000_0000);
    conclude();
  end
  initial
  begin
    repeat (90000) @(posedge clk_in);
    fails++;
    conclude();
  end
endmodule : dfc_top_tb_top
